//--- logic/occ_top.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module occ_top
   import occ_pkg::*;
#(
   parameter bit HAS_USB = 1'b1
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [31:0] RD_DATA,
   input wire logic FAIL_DETECT,
   input wire logic SWITCH_DONE,
   output logic SOSC_EN,
   output logic USB_FRC_SEL,
   output logic SWITCH_REQ,
   output logic [OCC_NOSC_W-1:0] NEW_OSC
);

   logic [OCC_SYNC_STAGES-1:0] sync_q [2];
   logic [1:0] filt_q;
   logic [1:0] pins;
   occ_lock_t lock_q, lock_d;
   logic cf_q;
   logic sosc_q;
   logic usbfrc_q;
   logic sw_q;
   logic [OCC_NOSC_W-1:0] nosc_q;
   logic fail_prev_q;
   logic done_prev_q;
   logic [31:0] rd_q;

   assign pins = {SWITCH_DONE, FAIL_DETECT};

   // Three stages per pin; value accepted only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               sync_q[gi] <= '0;
               filt_q[gi] <= 1'b0;
            end else if (CLK_EN) begin
               sync_q[gi] <= {sync_q[gi][1:0], pins[gi]};
               if (sync_q[gi][1] == sync_q[gi][2]) begin
                  filt_q[gi] <= sync_q[gi][2];
               end
            end
         end
      end
   endgenerate

   // Full byte compare, so unmapped offsets never alias onto a register
   function automatic logic addr_match(logic [7:0] a, logic [7:0] off);
      return a == off;
   endfunction

   wire fail_rise = filt_q[0] & ~fail_prev_q;
   wire done_rise = filt_q[1] & ~done_prev_q;
   wire ctrl_hit = addr_match(ADDR, OCC_CTRL_OFFSET);
   wire key_hit = addr_match(ADDR, OCC_UNLOCK_OFFSET);
   wire ctrl_wr = WR_STB & ctrl_hit & (lock_q == OCC_UNLOCKED);
   wire sw_set = ctrl_wr & WR_DATA[OCC_SWITCH_BIT];
   wire cf_clr = ctrl_wr & ~WR_DATA[OCC_FAIL_BIT];
   wire [31:0] ctrl_view = {21'h0_0000, nosc_q, 4'h0, cf_q, usbfrc_q, sosc_q, sw_q};
   wire [31:0] rd_sel = (RD_STB & ctrl_hit) ? ctrl_view : OCC_RD_RESET;

   // Any write but a key word to the unlock offset breaks a half-done key sequence; one unlock covers one control write
   always_comb begin
      lock_d = lock_q;
      if (WR_STB) begin
         if (key_hit && WR_DATA == OCC_KEY_FIRST) begin
            lock_d = OCC_KEY1_SEEN;
         end else if (key_hit && WR_DATA == OCC_KEY_SECOND && lock_q == OCC_KEY1_SEEN) begin
            lock_d = OCC_UNLOCKED;
         end else begin
            lock_d = OCC_LOCKED;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lock_q <= OCC_LOCKED;
         fail_prev_q <= 1'b0;
         done_prev_q <= 1'b0;
         rd_q <= OCC_RD_RESET;
      end else if (CLK_EN) begin
         lock_q <= lock_d;
         fail_prev_q <= filt_q[0];
         done_prev_q <= filt_q[1];
         rd_q <= rd_sel;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sosc_q <= 1'b0;
         usbfrc_q <= 1'b0;
         nosc_q <= OCC_NOSC_RESET;
      end else if (CLK_EN && ctrl_wr) begin
         sosc_q <= WR_DATA[OCC_SOSC_BIT];
         usbfrc_q <= HAS_USB & WR_DATA[OCC_USBFRC_BIT];
         nosc_q <= WR_DATA[OCC_NOSC_LSB +: OCC_NOSC_W];
      end
   end

   // Set wins over a same-cycle clear for both status bits: failure edge over software clear, software switch set over completion edge
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cf_q <= 1'b0;
         sw_q <= 1'b0;
      end else if (CLK_EN) begin
         if (fail_rise) begin
            cf_q <= 1'b1;
         end else if (cf_clr) begin
            cf_q <= 1'b0;
         end
         if (sw_set) begin
            sw_q <= 1'b1;
         end else if (done_rise) begin
            sw_q <= 1'b0;
         end
      end
   end

   assign RD_DATA = rd_q;
   assign SOSC_EN = sosc_q;
   assign USB_FRC_SEL = usbfrc_q;
   assign SWITCH_REQ = sw_q;
   assign NEW_OSC = nosc_q;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   // Clock-fail flag: set by a filtered failure edge, held until software clears it
   // A level that stays high must not re-set the flag after a clear, hence edges only
   AST_FAIL_SETS: assert property (CLK_EN && fail_rise |=> cf_q)
      else $error("clock fail flag not set after failure");
   AST_FAIL_QUIET: assert property (!cf_q && !(CLK_EN && fail_rise) |=> !cf_q)
      else $error("clock fail flag set without failure");
   AST_FAIL_STICKY: assert property (cf_q && !(CLK_EN && cf_clr) |=> cf_q)
      else $error("clock fail flag dropped without a clear");
   AST_FAIL_CLEAR: assert property (CLK_EN && cf_clr && !fail_rise |=> !cf_q)
      else $error("clock fail flag not cleared by write");
   AST_FAIL_EDGE_ONCE: assert property (CLK_EN && fail_rise |=> !fail_rise)
      else $error("failure edge lasted more than one cycle");
   AST_FILTER_HOLD: assert property (CLK_EN && sync_q[0][1] != sync_q[0][2]
      |=> $stable(filt_q[0]))
      else $error("failure filter moved while stages disagreed");

   // USB clock source and secondary oscillator follow accepted control writes
   AST_USB_SEL: assert property (CLK_EN && ctrl_wr
      |=> USB_FRC_SEL == (HAS_USB && $past(WR_DATA[OCC_USBFRC_BIT])))
      else $error("usb clock select did not follow write");
   AST_USB_ABSENT: assert property (!HAS_USB |-> !USB_FRC_SEL)
      else $error("usb select set on variant without usb");
   AST_SOSC: assert property (CLK_EN && ctrl_wr
      |=> SOSC_EN == $past(WR_DATA[OCC_SOSC_BIT]))
      else $error("secondary oscillator enable did not follow write");

   // Switch request: set by software, cleared only by a completion edge
   // Writing 0 does not cancel a pending switch; the oscillator side owns that
   AST_SWITCH_DONE: assert property (CLK_EN && done_rise && !sw_set |=> !SWITCH_REQ)
      else $error("switch request not cleared on completion");
   AST_SWITCH_START: assert property (CLK_EN && sw_set
      |=> SWITCH_REQ ##0 NEW_OSC == $past(WR_DATA[OCC_NOSC_LSB +: OCC_NOSC_W]))
      else $error("switch request not started");
   AST_SWITCH_HOLD: assert property (sw_q && !(CLK_EN && done_rise) |=> sw_q)
      else $error("switch request dropped before completion");
   AST_SWITCH_QUIET: assert property (!sw_q && !(CLK_EN && sw_set) |=> !sw_q)
      else $error("switch request rose without a write");
   AST_DONE_EDGE_ONCE: assert property (CLK_EN && done_rise |=> !done_rise)
      else $error("completion edge lasted more than one cycle");
   AST_NOSC: assert property (CLK_EN && ctrl_wr
      |=> NEW_OSC == $past(WR_DATA[OCC_NOSC_LSB +: OCC_NOSC_W]))
      else $error("new oscillator selection did not follow write");

   // Write protection: one unlock pair opens exactly one control write
   // Any stray write in between relocks, so a runaway store cannot slip through
   AST_LOCKED: assert property (WR_STB && ctrl_hit && lock_q != OCC_UNLOCKED
      |=> $stable(SOSC_EN) && $stable(NEW_OSC))
      else $error("locked write changed control");
   AST_RELOCK: assert property (CLK_EN && ctrl_wr |=> lock_q == OCC_LOCKED)
      else $error("unlock not consumed by control write");
   AST_KEY_PAIR: assert property (CLK_EN && WR_STB && key_hit && WR_DATA == OCC_KEY_SECOND
      && lock_q == OCC_KEY1_SEEN |=> lock_q == OCC_UNLOCKED)
      else $error("key pair did not unlock");
   AST_NO_SKIP: assert property (lock_q == OCC_LOCKED |=> lock_q != OCC_UNLOCKED)
      else $error("unlocked without first key");

   // Read port: answer stands one cycle only; a frozen clock enable holds everything
   AST_READ_ONCE: assert property (CLK_EN && !RD_STB |=> RD_DATA == OCC_RD_RESET)
      else $error("read data outside answer cycle");
   AST_RD_ANSWER: assert property (CLK_EN && RD_STB && ctrl_hit
      |=> RD_DATA[OCC_FAIL_BIT] == $past(cf_q) && RD_DATA[OCC_SWITCH_BIT] == $past(sw_q))
      else $error("read answer does not show status");
   AST_OTHER_READ_ZERO: assert property (CLK_EN && RD_STB && !ctrl_hit |=> RD_DATA == OCC_RD_RESET)
      else $error("unmapped read returned data");
   AST_FREEZE: assert property (!CLK_EN |=> $stable(RD_DATA) && $stable(SOSC_EN)
      && $stable(SWITCH_REQ) && $stable(NEW_OSC))
      else $error("state moved while clock enable low");

   // Main scenarios the bench is expected to reach
   COV_UNLOCK_WRITE: cover property (lock_q == OCC_KEY1_SEEN ##1 lock_q == OCC_UNLOCKED ##1 ctrl_wr);
   COV_SWITCH: cover property (sw_set ##[1:20] done_rise);
   COV_FAIL: cover property (fail_rise ##1 cf_q);
   COV_RELOCK: cover property (CLK_EN && ctrl_wr ##1 lock_q == OCC_LOCKED);
   COV_FROZEN_WRITE: cover property (!CLK_EN && WR_STB);
endmodule

//--- logic/occ_pkg.sv
package occ_pkg;
   localparam logic [7:0] OCC_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] OCC_UNLOCK_OFFSET = 8'h04;
   localparam int OCC_SWITCH_BIT = 0;
   localparam int OCC_SOSC_BIT = 1;
   localparam int OCC_USBFRC_BIT = 2;
   localparam int OCC_FAIL_BIT = 3;
   localparam int OCC_NOSC_LSB = 8;
   localparam int OCC_NOSC_W = 3;
   // Key values are arbitrary
   localparam logic [31:0] OCC_KEY_FIRST = 32'hC0DE_0001;
   localparam logic [31:0] OCC_KEY_SECOND = 32'hC0DE_0002;
   localparam logic [OCC_NOSC_W-1:0] OCC_NOSC_RESET = 3'h0;
   localparam logic [31:0] OCC_RD_RESET = 32'h0000_0000;
   localparam int OCC_SYNC_STAGES = 3;
   typedef enum logic [1:0] {OCC_LOCKED, OCC_KEY1_SEEN, OCC_UNLOCKED} occ_lock_t;
endpackage

//--- sim/occ_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module occ_top_test;
   import occ_pkg::*;
   logic SYS_CLK = 0, RESET_N = 0, CLK_EN = 1, WR_STB = 0, RD_STB = 0;
   logic FAIL_DETECT = 0, SWITCH_DONE = 0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WR_DATA = 32'h0000_0000, RD_DATA, q, d;
   logic SOSC_EN, USB_FRC_SEL, SWITCH_REQ;
   logic [OCC_NOSC_W-1:0] NEW_OSC;
   int fails = 0, num_checks = 0;
   occ_top u_occ_top (.SYS_CLK, .RESET_N, .CLK_EN, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
      .RD_DATA, .FAIL_DETECT, .SWITCH_DONE, .SOSC_EN, .USB_FRC_SEL, .SWITCH_REQ, .NEW_OSC);
   always #25 SYS_CLK = ~SYS_CLK;
   function automatic logic [31:0] exp_rd(logic [31:0] v, logic cf, logic sw);
      return {21'h0, v[10:8], 4'h0, cf, v[2], v[1], sw};
   endfunction
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WR_DATA <= v;
      WR_STB <= 1'b1;
      @(posedge SYS_CLK);
      WR_STB <= 1'b0;
   endtask
   // Data is only valid in the cycle after the strobe, so sample just past that edge
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge SYS_CLK);
      RD_STB <= 1'b0;
      #1 v = RD_DATA;
   endtask
   task automatic uwr(logic [31:0] v);
      wr(OCC_UNLOCK_OFFSET, OCC_KEY_FIRST);
      wr(OCC_UNLOCK_OFFSET, OCC_KEY_SECOND);
      wr(OCC_CTRL_OFFSET, v);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hf634));
      repeat (3) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      rd(OCC_CTRL_OFFSET, q);
      `CHK("reset", OCC_RD_RESET, q)
      wr(OCC_CTRL_OFFSET, 32'h0000_0706);
      rd(OCC_CTRL_OFFSET, q);
      `CHK("locked", 32'h0000_0000, q)
      for (int i = 0; i < 8; i++) begin
         d = $urandom & 32'h0000_0706;
         uwr(d);
         rd(OCC_CTRL_OFFSET, q);
         `CHK("ctrl", exp_rd(d, 1'b0, 1'b0), q)
         `CHK("sosc", d[1], SOSC_EN)
         `CHK("usbfrc", d[2], USB_FRC_SEL)
         `CHK("nosc", d[10:8], NEW_OSC)
         // Odd passes give only the first key, which must still leave it locked
         if (i[0]) wr(OCC_UNLOCK_OFFSET, OCC_KEY_FIRST);
         wr(OCC_CTRL_OFFSET, d ^ 32'h0000_0706);
         rd(OCC_CTRL_OFFSET, q);
         `CHK("relock", exp_rd(d, 1'b0, 1'b0), q)
      end
      uwr(d | 32'h0000_0001);
      rd(OCC_CTRL_OFFSET, q);
      `CHK("swreq", exp_rd(d, 1'b0, 1'b1), q)
      @(posedge SYS_CLK);
      SWITCH_DONE <= 1'b1;
      for (int n = 0; n < 20 && SWITCH_REQ !== 1'b0; n++) @(posedge SYS_CLK);
      `CHK("swtimeout", 1'b0, SWITCH_REQ)
      rd(OCC_CTRL_OFFSET, q);
      `CHK("swdone", exp_rd(d, 1'b0, 1'b0), q)
      @(posedge SYS_CLK);
      SWITCH_DONE <= 1'b0;
      FAIL_DETECT <= 1'b1;
      for (int n = 0; n < 12 && q[3] !== 1'b1; n++) rd(OCC_CTRL_OFFSET, q);
      `CHK("cfset", exp_rd(d, 1'b1, 1'b0), q)
      FAIL_DETECT <= 1'b0;
      uwr(d);
      rd(OCC_CTRL_OFFSET, q);
      `CHK("cfclr", exp_rd(d, 1'b0, 1'b0), q)
      // Clock enable low: a full unlock and write must leave the control untouched
      @(posedge SYS_CLK);
      CLK_EN <= 1'b0;
      uwr(d ^ 32'h0000_0002);
      CLK_EN <= 1'b1;
      rd(OCC_CTRL_OFFSET, q);
      `CHK("frozen", exp_rd(d, 1'b0, 1'b0), q)
      print_verdict();
   end
endmodule
